// file: rtl/led_regs_pkg.sv
/*
 * Package for the three-channel LED current and slope-time register slice.
 * Holds register offsets, reset values, field positions, step codes and timing counts.
 * Assumes a 250 MHz core clock and a byte-wide register port.
 */
package led_regs_pkg;

    // Register offsets
    localparam logic [7:0] OFF_SOFT_RESET  = 8'h00;
    localparam logic [7:0] OFF_ENABLE_MODE = 8'h01;
    localparam logic [7:0] OFF_CONFIG      = 8'h02;
    localparam logic [7:0] OFF_CH1_CC      = 8'h03;
    localparam logic [7:0] OFF_CH2_CC      = 8'h04;
    localparam logic [7:0] OFF_CH3_CC      = 8'h05;
    localparam logic [7:0] OFF_CH1_SLP     = 8'h06;
    localparam logic [7:0] OFF_CH2_SLP     = 8'h07;
    localparam logic [7:0] OFF_CH3_SLP     = 8'h08;

    // Reset values
    localparam logic [7:0] RST_CC          = 8'h00;
    localparam logic [7:0] RST_SLP         = 8'h88;
    localparam logic [7:0] RST_CONFIG      = 8'h40;
    localparam logic [7:0] RST_ENABLE_MODE = 8'h00;

    // Field positions
    localparam int MAXSEL_LSB    = 6;
    localparam int PH12_LSB      = 0;
    localparam int PH34_LSB      = 4;
    localparam int SOFT_RESET_BIT_BIT    = 0;
    localparam int ENABLE_LSB    = 0;
    localparam int MODE_LSB      = 4;

    // Current step in microamps per code, by max-current field value
    localparam logic [8:0] STEP_UA_00 = 9'h032;
    localparam logic [8:0] STEP_UA_01 = 9'h064;
    localparam logic [8:0] STEP_UA_10 = 9'h07d;
    localparam logic [8:0] STEP_UA_11 = 9'h0fa;

    // Slope time unit: PWM cycle count per nibble count and PWM period
    localparam real PWM_CYCLE_US   = 53.3;
    localparam int  PWM_PER_UNIT_A = 75;
    localparam int  PWM_PER_UNIT_B = 125;
    localparam int  PWM_PER_UNIT   = PWM_PER_UNIT_A * PWM_PER_UNIT_B;
    localparam real CLOCK_MHZ      = 250.0;
    localparam int  PWM_CYCLE_CLKS = int'(PWM_CYCLE_US * CLOCK_MHZ);

endpackage : led_regs_pkg

// file: rtl/led_current_slope_time_regs.sv
/*
 * Register slice of a three-channel LED driver: current codes, slope total times,
 * the shared max-current field, enable and mode bits, and a self-clearing soft reset.
 * Assumes the serial front end delivers single-cycle byte read/write strobes in the
 * same clock domain; the analog sinks and slope sequencer sit outside.
 */
module led_current_slope_time_regs (
    input  wire logic        clock,        // Core clock, 250 MHz
    input  wire logic        sys_rst,      // Asynchronous reset, active high
    input  wire logic        reg_wr,       // Write strobe, one cycle
    input  wire logic        reg_rd,       // Read strobe, one cycle
    input  wire logic [7:0]  reg_addr,     // Register offset
    input  wire logic [7:0]  reg_wdata,    // Write data
    output logic      [7:0]  reg_rdata,    // Read data, valid cycle after reg_rd
    output logic      [17:0] ch1_current_ua, // Channel one target current, microamps
    output logic      [17:0] ch2_current_ua, // Channel two target current, microamps
    output logic      [17:0] ch3_current_ua, // Channel three target current, microamps
    output logic      [2:0]  ch_output_enable, // Per-channel output on
    output logic      [2:0]  ch_slope_mode_sel, // Per-channel slope mode
    output logic      [3:0]  ch1_phase12_time, // Channel one phases 1-2, 0.5 s units
    output logic      [3:0]  ch1_phase34_time, // Channel one phases 3-4, 0.5 s units
    output logic      [3:0]  ch2_phase12_time, // Channel two phases 1-2
    output logic      [3:0]  ch2_phase34_time, // Channel two phases 3-4
    output logic      [3:0]  ch3_phase12_time, // Channel three phases 1-2
    output logic      [3:0]  ch3_phase34_time  // Channel three phases 3-4
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0]  enable_mode;
        logic [7:0]  config_reg;
        logic [7:0]  cc1;
        logic [7:0]  cc2;
        logic [7:0]  cc3;
        logic [7:0]  slp1;
        logic [7:0]  slp2;
        logic [7:0]  slp3;
        logic [7:0]  rdata;
        logic [17:0] cur1;
        logic [17:0] cur2;
        logic [17:0] cur3;
    } state_s;

    state_s st_q;
    state_s st_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Step size per code from the two-bit max-current field
    function automatic logic [8:0] step_ua(input logic [1:0] sel);
        logic [8:0] s;
        unique case (sel)
            2'b00:   s = led_regs_pkg::STEP_UA_00;
            2'b01:   s = led_regs_pkg::STEP_UA_01;
            2'b10:   s = led_regs_pkg::STEP_UA_10;
            default: s = led_regs_pkg::STEP_UA_11;
        endcase
        return s;
    endfunction

    // Current in microamps; code zero gives zero since the product is zero
    function automatic logic [17:0] current_ua(input logic [7:0] code, input logic [1:0] sel);
        logic [16:0] p;
        p = code * step_ua(sel);
        return {1'b0, p};
    endfunction

    // Reset image of every register; used by the soft reset only
    function automatic state_s defaults();
        state_s s;
        s             = '0;
        s.enable_mode = led_regs_pkg::RST_ENABLE_MODE;
        s.config_reg  = led_regs_pkg::RST_CONFIG;
        s.cc1         = led_regs_pkg::RST_CC;
        s.cc2         = led_regs_pkg::RST_CC;
        s.cc3         = led_regs_pkg::RST_CC;
        s.slp1        = led_regs_pkg::RST_SLP;
        s.slp2        = led_regs_pkg::RST_SLP;
        s.slp3        = led_regs_pkg::RST_SLP;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    // Writes land directly in the live registers, so there is no shadow copy to commit
    always_comb begin
        logic [1:0] sel;
        st_d = st_q;
        sel  = 2'b00;
        if (reg_wr) begin
            unique case (reg_addr)
                led_regs_pkg::OFF_SOFT_RESET: begin
                    // Reset bit never stores, so it reads back as zero afterwards
                    if (reg_wdata[led_regs_pkg::SOFT_RESET_BIT_BIT]) begin
                        st_d       = defaults();
                        st_d.rdata = st_q.rdata; // Read data stands until the next read
                    end
                end
                led_regs_pkg::OFF_ENABLE_MODE: st_d.enable_mode = reg_wdata & 8'h77;
                led_regs_pkg::OFF_CONFIG:      st_d.config_reg  = reg_wdata;
                led_regs_pkg::OFF_CH1_CC:      st_d.cc1  = reg_wdata;
                led_regs_pkg::OFF_CH2_CC:      st_d.cc2  = reg_wdata;
                led_regs_pkg::OFF_CH3_CC:      st_d.cc3  = reg_wdata;
                led_regs_pkg::OFF_CH1_SLP:     st_d.slp1 = reg_wdata;
                led_regs_pkg::OFF_CH2_SLP:     st_d.slp2 = reg_wdata;
                led_regs_pkg::OFF_CH3_SLP:     st_d.slp3 = reg_wdata;
                default: ;
            endcase
        end
        // Read data captured one cycle after the strobe; unmapped offsets read zero
        if (reg_rd) begin
            unique case (reg_addr)
                led_regs_pkg::OFF_ENABLE_MODE: st_d.rdata = st_q.enable_mode;
                led_regs_pkg::OFF_CONFIG:      st_d.rdata = st_q.config_reg;
                led_regs_pkg::OFF_CH1_CC:      st_d.rdata = st_q.cc1;
                led_regs_pkg::OFF_CH2_CC:      st_d.rdata = st_q.cc2;
                led_regs_pkg::OFF_CH3_CC:      st_d.rdata = st_q.cc3;
                led_regs_pkg::OFF_CH1_SLP:     st_d.rdata = st_q.slp1;
                led_regs_pkg::OFF_CH2_SLP:     st_d.rdata = st_q.slp2;
                led_regs_pkg::OFF_CH3_SLP:     st_d.rdata = st_q.slp3;
                default:                       st_d.rdata = 8'h00;
            endcase
        end
        // Current outputs follow the code registers one cycle later, all channels
        sel       = st_q.config_reg[led_regs_pkg::MAXSEL_LSB +: 2];
        st_d.cur1 = current_ua(st_q.cc1, sel);
        st_d.cur2 = current_ua(st_q.cc2, sel);
        st_d.cur3 = current_ua(st_q.cc3, sel);
    end

    // State register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            // Constants only here; the soft reset goes through defaults() instead
            st_q.enable_mode <= led_regs_pkg::RST_ENABLE_MODE;
            st_q.config_reg  <= led_regs_pkg::RST_CONFIG;
            st_q.cc1         <= led_regs_pkg::RST_CC;
            st_q.cc2         <= led_regs_pkg::RST_CC;
            st_q.cc3         <= led_regs_pkg::RST_CC;
            st_q.slp1        <= led_regs_pkg::RST_SLP;
            st_q.slp2        <= led_regs_pkg::RST_SLP;
            st_q.slp3        <= led_regs_pkg::RST_SLP;
            st_q.rdata       <= 8'h00;
            st_q.cur1        <= 18'h0_0000;
            st_q.cur2        <= 18'h0_0000;
            st_q.cur3        <= 18'h0_0000;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // All outputs are flops of the state struct
    assign reg_rdata         = st_q.rdata;
    assign ch1_current_ua    = st_q.cur1;
    assign ch2_current_ua    = st_q.cur2;
    assign ch3_current_ua    = st_q.cur3;
    assign ch_output_enable  = st_q.enable_mode[led_regs_pkg::ENABLE_LSB +: 3];
    assign ch_slope_mode_sel = st_q.enable_mode[led_regs_pkg::MODE_LSB +: 3];
    // Same nibble split for every channel
    assign ch1_phase12_time  = st_q.slp1[led_regs_pkg::PH12_LSB +: 4];
    assign ch1_phase34_time  = st_q.slp1[led_regs_pkg::PH34_LSB +: 4];
    assign ch2_phase12_time  = st_q.slp2[led_regs_pkg::PH12_LSB +: 4];
    assign ch2_phase34_time  = st_q.slp2[led_regs_pkg::PH34_LSB +: 4];
    assign ch3_phase12_time  = st_q.slp3[led_regs_pkg::PH12_LSB +: 4];
    assign ch3_phase34_time  = st_q.slp3[led_regs_pkg::PH34_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_CC1_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h03 ##1 reg_rd && reg_addr == 8'h03 && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("channel one code readback wrong");

    AST_CC2_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h04 |=> st_q.cc2 == $past(reg_wdata))
        else $error("channel two code not stored");

    AST_CC3_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h05 |=> st_q.cc3 == $past(reg_wdata))
        else $error("channel three code not stored");

    AST_CURRENT: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_wr ##1 !reg_wr |-> ch1_current_ua == 18'(st_q.cc1 *
            (st_q.config_reg[7:6] == 2'b00 ? 50 : st_q.config_reg[7:6] == 2'b01 ? 100 :
             st_q.config_reg[7:6] == 2'b10 ? 125 : 250)))
        else $error("channel one current mismatch");

    AST_SLP1: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h06 |=> {ch1_phase34_time, ch1_phase12_time} == $past(reg_wdata))
        else $error("channel one slope time not stored");

    AST_SLP2: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h07 |=> {ch2_phase34_time, ch2_phase12_time} == $past(reg_wdata))
        else $error("channel two slope time not stored");

    AST_SLP3: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h08 |=> ch3_phase12_time == $past(reg_wdata[3:0]) &&
            ch3_phase34_time == $past(reg_wdata[7:4]))
        else $error("channel three slope time not stored");

    AST_SOFT_RESET: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h00 && reg_wdata[0] |=> st_q.slp2 == 8'h88 &&
            st_q.config_reg == 8'h40 && st_q.cc1 == 8'h00 && ch_output_enable == 3'b000)
        else $error("soft reset did not restore defaults");

    // Channel one code lands in its register the cycle after the write
    AST_CC1_STORE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == led_regs_pkg::OFF_CH1_CC |=> st_q.cc1 == $past(reg_wdata))
        else $error("channel one code not stored");

    // Channel two current once the code and step have settled
    AST_CURRENT2: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_wr ##1 !reg_wr |-> ch2_current_ua == 18'(st_q.cc2 *
            (st_q.config_reg[7:6] == 2'b00 ? 50 : st_q.config_reg[7:6] == 2'b01 ? 100 :
             st_q.config_reg[7:6] == 2'b10 ? 125 : 250)))
        else $error("channel two current mismatch");

    // Channel three current once the code and step have settled
    AST_CURRENT3: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_wr ##1 !reg_wr |-> ch3_current_ua == 18'(st_q.cc3 *
            (st_q.config_reg[7:6] == 2'b00 ? 50 : st_q.config_reg[7:6] == 2'b01 ? 100 :
             st_q.config_reg[7:6] == 2'b10 ? 125 : 250)))
        else $error("channel three current mismatch");

    // Code zero drives no current whatever the step
    AST_ZERO_CODE: assert property (@(posedge clock) disable iff (sys_rst)
        st_q.cc1 == 8'h00 && !reg_wr |=> ch1_current_ua == 18'h0_0000)
        else $error("zero code gave current");

    // A channel one slope write leaves channel two timing alone
    AST_CH_ISOLATE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == led_regs_pkg::OFF_CH1_SLP
        |=> $stable(ch2_phase12_time) && $stable(ch2_phase34_time))
        else $error("channel two slope time disturbed");

    // Phases three-four time only moves on its own write or a soft reset
    AST_PH34_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        !(reg_wr && (reg_addr == led_regs_pkg::OFF_CH1_SLP ||
                     reg_addr == led_regs_pkg::OFF_SOFT_RESET)) |=> $stable(ch1_phase34_time))
        else $error("channel one phase three-four time changed");

    // Max-current field follows the configuration write
    AST_CONFIG: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == led_regs_pkg::OFF_CONFIG
        |=> st_q.config_reg[7:6] == $past(reg_wdata[7:6]))
        else $error("max-current field not stored");

    // Enable and mode outputs follow their register write
    AST_ENABLE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == led_regs_pkg::OFF_ENABLE_MODE
        |=> ch_output_enable == $past(reg_wdata[2:0]) &&
            ch_slope_mode_sel == $past(reg_wdata[6:4]))
        else $error("enable or mode bits not stored");

    // Soft reset returns channel one and three slope times, codes two and three and the modes to default
    AST_SOFT_RESET_BIT_SLP: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h00 && reg_wdata[0] |=> ch1_phase12_time == 4'h8 &&
            ch1_phase34_time == 4'h8 && ch3_phase12_time == 4'h8 &&
            ch3_phase34_time == 4'h8 && st_q.cc2 == 8'h00 && st_q.cc3 == 8'h00 &&
            ch_slope_mode_sel == 3'b000)
        else $error("soft reset left slope state behind");

    // The reset bit is never stored, so it reads as zero
    AST_RD_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == led_regs_pkg::OFF_SOFT_RESET |=> reg_rdata == 8'h00)
        else $error("soft reset offset read nonzero");

    // Read data stands until the next read strobe
    AST_RD_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // Offsets above the map read as zero
    AST_RD_UNMAPPED: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr > led_regs_pkg::OFF_CH3_SLP |=> reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");

    // A read returns the value held in the register at the strobe
    AST_RD_CC2: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == led_regs_pkg::OFF_CH2_CC |=> reg_rdata == $past(st_q.cc2))
        else $error("channel two code read wrong");

    // Unused bits of the enable and mode register read as zero
    AST_MODE_MASK: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == led_regs_pkg::OFF_ENABLE_MODE |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("unused enable register bits read set");

endmodule // led_current_slope_time_regs

// file: dv/led_host_model.sv
/* Host model: the serial front end reduced to byte strobes.
   Assumes the slice samples strobes on the rising clock edge. */
module led_host_model (
    input  wire logic       clock,     // Core clock
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    output logic      [7:0] reg_addr,  // Register offset
    output logic      [7:0] reg_wdata, // Write data
    input  wire logic [7:0] reg_rdata  // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hA5;
        reg_wdata = 8'h5A;
    end
    // One write; released write data shows the inverse so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Write, then read the same offset in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        q = reg_rdata;
    endtask
    // One read; data is taken once the strobe edge has passed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // led_host_model

// file: dv/test_led_current_slope_time_regs.sv
/* Self-checking bench for the LED current and slope-time register slice.
   Assumes the host model and the design are compiled first. */
`define CHK(nm, ex, got) begin \
    checked++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
end
module test_led_current_slope_time_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock;
    logic        sys_rst;
    logic        reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [17:0] ch1_current_ua, ch2_current_ua, ch3_current_ua;
    logic [2:0]  ch_output_enable, ch_slope_mode_sel;
    logic [3:0]  ch1_phase12_time, ch1_phase34_time, ch2_phase12_time;
    logic [3:0]  ch2_phase34_time, ch3_phase12_time, ch3_phase34_time;
    wire  [23:0] phases = {ch3_phase34_time, ch3_phase12_time, ch2_phase34_time,
                           ch2_phase12_time, ch1_phase34_time, ch1_phase12_time};
    int          err_total = 0;
    int          checked = 0;
    ////////////////////////////////////////////////////////////////////////////
    led_current_slope_time_regs DUT (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .ch1_current_ua, .ch2_current_ua, .ch3_current_ua,
        .ch_output_enable, .ch_slope_mode_sel, .ch1_phase12_time, .ch1_phase34_time,
        .ch2_phase12_time, .ch2_phase34_time, .ch3_phase12_time, .ch3_phase34_time);
    led_host_model host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read through the host and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        host.rd(a, d);
        `CHK("read data", ex, d)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Defaults straight after reset
    task automatic t_reset_values();
        rchk(8'h02, 8'h40);
        rchk(8'h03, 8'h00);
        rchk(8'h04, 8'h00);
        rchk(8'h05, 8'h00);
        rchk(8'h06, 8'h88);
        rchk(8'h07, 8'h88);
        rchk(8'h08, 8'h88);
        `CHK("phases", 24'h88_8888, phases)
    endtask
    // Extreme nibbles on channels one and two, 5 and A on three, so a swapped half shows at once
    task automatic t_slope();
        host.wr(8'h06, 8'hF0);
        host.wr(8'h07, 8'h0F);
        host.wr(8'h08, 8'h5A);
        @(negedge clock);
        `CHK("phases", 24'h5A_0FF0, phases)
        `CHK("ch1 phase34", 4'hF, ch1_phase34_time)
        rchk(8'h06, 8'hF0);
        rchk(8'h07, 8'h0F);
        rchk(8'h08, 8'h5A);
    endtask
    // Every step code against full, unit and mid codes
    task automatic t_current();
        logic [17:0] step [4] = '{18'h0_0032, 18'h0_0064, 18'h0_007D, 18'h0_00FA};
        host.wr(8'h03, 8'hFF);
        host.wr(8'h04, 8'h01);
        host.wr(8'h05, 8'h80);
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h02, {s[1:0], 6'h00});
            repeat (2) @(negedge clock);
            `CHK("ch1 current", step[s] * 18'h0_00FF, ch1_current_ua)
            `CHK("ch2 current", step[s], ch2_current_ua)
            `CHK("ch3 current", step[s] * 18'h0_0080, ch3_current_ua)
            rchk(8'h02, {s[1:0], 6'h00});
        end
        host.wr(8'h04, 8'h00);
        repeat (2) @(negedge clock);
        `CHK("ch2 current", 18'h0_0000, ch2_current_ua)
    endtask
    // Enable and mode bits, unused bits read back zero
    task automatic t_mode();
        host.wr(8'h01, 8'hFF);
        rchk(8'h01, 8'h77);
        `CHK("enables", 3'h7, ch_output_enable)
        host.wr(8'h01, 8'h21);
        @(negedge clock);
        `CHK("enables", 3'h1, ch_output_enable)
        `CHK("modes", 3'h2, ch_slope_mode_sel)
    endtask
    // Unmapped write ignored, then soft reset restores every default
    task automatic t_soft_reset();
        host.wr(8'h20, 8'hFF);
        rchk(8'h20, 8'h00);
        host.wr(8'h00, 8'h01);
        @(negedge clock);
        `CHK("enables", 3'h0, ch_output_enable)
        `CHK("phases", 24'h88_8888, phases)
        rchk(8'h00, 8'h00);
        rchk(8'h02, 8'h40);
        rchk(8'h03, 8'h00);
        rchk(8'h06, 8'h88);
        `CHK("ch1 current", 18'h0_0000, ch1_current_ua)
    endtask
    // Read in the cycle after a write sees the new code; current follows
    task automatic t_back_to_back();
        logic [7:0] d;
        host.wr_rd(8'h03, 8'h0A, d);
        `CHK("ch1 code readback", 8'h0A, d)
        `CHK("ch1 current", 18'h0_03E8, ch1_current_ua)
    endtask
    // Hard reset in mid-run returns written registers to defaults
    task automatic t_hard_reset();
        host.wr(8'h05, 8'h33);
        host.wr(8'h07, 8'h12);
        host.wr(8'h01, 8'h07);
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        `CHK("enables", 3'h0, ch_output_enable)
        rchk(8'h05, 8'h00);
        rchk(8'h07, 8'h88);
        `CHK("ch1 current", 18'h0_0000, ch1_current_ua)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 8 cycles, released off the sampling edge
    initial begin
        sys_rst = 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        t_reset_values();
        t_slope();
        t_current();
        t_mode();
        t_soft_reset();
        t_back_to_back();
        t_hard_reset();
        test_done();
    end
    // Watchdog so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("[FAIL] run length expected finish seen timeout");
        test_done();
    end
endmodule // test_led_current_slope_time_regs
